// ### common/fpep_pkg.sv
// ============================================================
// Shared constants and types for the program, erase and protection block.
package fpep_pkg;

	// ============================================================
	// Clock and timing.
	localparam int CLK_PERIOD_NS   = 8;
	localparam int SR_WRITE_NS     = 10000;
	localparam int SR_WRITE_CYCLES = (SR_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W         = 16;

	// ============================================================
	// Array geometry, 20-bit byte addresses.
	localparam int          ADDR_W        = 20;
	localparam logic [19:0] ADDR_MAX      = 20'hfffff;
	localparam logic [19:0] ADDR_MIN      = 20'h00000;
	localparam logic [19:0] PAGE_MASK     = 20'h000ff;
	localparam logic [19:0] SECTOR_MASK   = 20'h00fff;
	localparam logic [19:0] BLOCK32_MASK  = 20'h07fff;
	localparam logic [19:0] BLOCK64_MASK  = 20'h0ffff;
	localparam logic [19:0] SECTOR_BYTES  = 20'h01000;
	localparam logic [19:0] BLOCK64_BYTES = 20'h10000;
	localparam logic [8:0]  PAGE_BYTES    = 9'h100;
	localparam logic [7:0]  ERASED_BYTE   = 8'hff;

	// ============================================================
	// Instruction codes.
	localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
	localparam logic [7:0] OP_PAGE_WRITE    = 8'h02;
	localparam logic [7:0] OP_SECTOR_CLEAR  = 8'h20;
	localparam logic [7:0] OP_BLOCK32_CLEAR = 8'h52;
	localparam logic [7:0] OP_BLOCK64_CLEAR = 8'hd8;
	localparam logic [7:0] OP_CHIP_CLEAR_A  = 8'hc7;
	localparam logic [7:0] OP_CHIP_CLEAR_B  = 8'h60;
	localparam logic [7:0] OP_ENTER_SLEEP   = 8'hb9;
	localparam logic [7:0] OP_WAKE_AND_ID   = 8'hab;

	// ============================================================
	// Status byte field positions.
	localparam int SR0_LEVEL_LSB = 2;
	localparam int SR0_TB_BIT    = 5;
	localparam int SR0_SEC_BIT   = 6;
	localparam int SR1_CMP_BIT   = 6;

	// ============================================================
	// Types.
	typedef struct packed {
		logic       complement_protect;
		logic       fine_granularity_flag;
		logic       top_bottom_choice;
		logic [2:0] protect_level_bits;
	} fpep_prot_t;

	localparam fpep_prot_t PROT_RESET = '0;

	typedef struct packed {
		logic [7:0]  opcode;
		logic [23:0] addr;
		logic        whole_bytes;
	} fpep_cmd_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} fpep_arr_req_t;

	typedef enum logic [1:0] {PWR_STANDBY, PWR_ACTIVE, PWR_SLEEP} fpep_power_t;

	typedef enum logic [2:0] {ST_IDLE, ST_SR_WAIT, ST_PG_READ, ST_PG_WAIT, ST_PG_MERGE,
		ST_ERASE} fpep_state_t;

endpackage

// ### logic/fpep_page_buf.sv
`timescale 1ns/1ns
// ============================================================
// Page data buffer, 256 bytes, registered read.
module fpep_page_buf
(
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// Write port.
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	// Read port.
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data
);

	logic [7:0] mem [0:255];

	always_ff @(posedge ref_clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			rd_data <= '0;
		end
		else
		begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule

// ### logic/fpep_core.sv
`timescale 1ns/1ns
// Notes on behaviour
// R1: Complement on: level 000 all, 101/11x none; the code leaves 32 kB unprotected at fine level 101.
// R2: Coarse complement levels leave top or bottom fraction.
// R3: Fine complement levels leave 4 to 32 kB.
// R4: Any protected byte in target: command ignored.
// R5: Host sends write enable before page write.
// R6: Page write: up to 256 bytes, one page.
// R7: Programming only clears bits, never sets them.
// R8: Erase makes every targeted byte FFh.
// R9: Sector, block and chip erase supported.
// R10: Host sends write enable before every erase.
// R11: Busy flag high for whole internal cycle.
// R12: Chip select low means active power state.
// R13: Stay active until internal cycle ends.
// R14: Enter-sleep instruction enters deep power-down.
// R15: Only wake instruction leaves deep power-down.
// R16: Deep power-down ignores all other instructions.
// R17: Cycle completion clears the write enable latch.
// R18: Wake instruction opcode is ABh.
// R19: Write-type commands need whole bytes clocked.
// R20: Busy device ignores further instructions.
// R21: Protection checked with bits at acceptance.
module fpep_core
(
	// Clock and reset.
	input  wire logic                   ref_clk,
	input  wire logic                   reset_n,
	// Chip select pin.
	input  wire logic                   chip_sel_n_pin,
	// Decoded frame from the serial front end.
	input  wire logic                   fe_byte_valid,
	input  wire logic [7:0]             fe_byte,
	input  wire logic                   fe_cmd_valid,
	input  wire fpep_pkg::fpep_cmd_t    fe_cmd,
	// Array port.
	output fpep_pkg::fpep_arr_req_t     arr_req,
	input  wire logic [7:0]             arr_rdata,
	// Status.
	output logic                        write_in_progress_flag,
	output logic                        write_enable_latch,
	output fpep_pkg::fpep_prot_t        prot_bits,
	output fpep_pkg::fpep_power_t       power_state
);

	// ============================================================
	// Chip select synchroniser.
	logic cs_meta_reg;
	logic cs_sync_reg;

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
		end
		else
		begin
			cs_meta_reg <= chip_sel_n_pin;
			cs_sync_reg <= cs_meta_reg;
		end
	end

	// ============================================================
	// Protection check: true when [lo, hi] touches a protected byte.
	function automatic logic hits_protect(input fpep_pkg::fpep_prot_t p,
		input logic [19:0] lo, input logic [19:0] hi);
		logic        any;
		logic        all;
		logic [1:0]  shift;
		logic [19:0] size;
		logic [19:0] plo;
		logic [19:0] phi;
		any = (p.protect_level_bits != 3'h0);
		all = (p.protect_level_bits[2:1] == 2'h3) ||
			(p.protect_level_bits == 3'h5 && !p.fine_granularity_flag);
		if (p.protect_level_bits[2])
			shift = 2'h3;
		else
			shift = 2'(p.protect_level_bits - 3'h1);
		if (p.fine_granularity_flag)
			size = fpep_pkg::SECTOR_BYTES << shift;
		else
			size = fpep_pkg::BLOCK64_BYTES << shift;
		if (all)
		begin
			plo = fpep_pkg::ADDR_MIN;
			phi = fpep_pkg::ADDR_MAX;
		end
		else if (p.top_bottom_choice)
		begin
			plo = fpep_pkg::ADDR_MIN;
			phi = size - 20'h1;
		end
		else
		begin
			plo = fpep_pkg::ADDR_MAX - size + 20'h1;
			phi = fpep_pkg::ADDR_MAX;
		end
		if (p.complement_protect)
			hits_protect = !(any && lo >= plo && hi <= phi); // R1 R2 R3
		else
			hits_protect = any && lo <= phi && hi >= plo;
	endfunction

	// ============================================================
	// Command state.
	fpep_pkg::fpep_state_t   state_reg,   state_next;
	fpep_pkg::fpep_prot_t    prot_reg,    prot_next;
	fpep_pkg::fpep_arr_req_t arr_reg,     arr_next;
	fpep_pkg::fpep_power_t   power_reg,   power_next;
	logic                    wel_reg,     wel_next;
	logic                    sleep_reg,   sleep_next;
	logic [8:0]              cnt_reg,     cnt_next;
	logic [7:0]              sr0_reg,     sr0_next;
	logic [7:0]              sr1_reg,     sr1_next;
	logic [8:0]              left_reg,    left_next;
	logic [7:0]              off_reg,     off_next;
	logic [7:0]              idx_reg,     idx_next;
	logic [19:0]             page_reg,    page_next;
	logic [19:0]             cur_reg,     cur_next;
	logic [19:0]             end_reg,     end_next;
	logic [fpep_pkg::TIMER_W-1:0] timer_reg, timer_next;

	logic        buf_wr;
	logic [7:0]  buf_rdata;
	logic [19:0] cmd_addr;
	logic [19:0] lo;
	logic [19:0] hi;
	logic        is_erase;
	logic        is_page;
	logic        write_type;

	assign cmd_addr = fe_cmd.addr[19:0];
	assign buf_wr   = fe_byte_valid && state_reg == fpep_pkg::ST_IDLE && !sleep_reg; // R16 R20

	fpep_page_buf u_buf
	(
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.wr_en   (buf_wr),
		.wr_addr (cnt_reg[7:0]),
		.wr_data (fe_byte),
		.rd_addr (idx_reg),
		.rd_data (buf_rdata)
	);

	// ============================================================
	// Target region of the incoming command.
	always_comb
	begin
		lo       = cmd_addr;
		hi       = cmd_addr;
		is_erase = 1'b1;
		is_page  = 1'b0;
		if (fe_cmd.opcode == fpep_pkg::OP_PAGE_WRITE)
		begin
			is_erase = 1'b0;
			is_page  = 1'b1;
			lo       = cmd_addr & ~fpep_pkg::PAGE_MASK; // R6
			hi       = cmd_addr | fpep_pkg::PAGE_MASK;
		end
		else if (fe_cmd.opcode == fpep_pkg::OP_SECTOR_CLEAR)
		begin
			lo = cmd_addr & ~fpep_pkg::SECTOR_MASK; // R9
			hi = cmd_addr | fpep_pkg::SECTOR_MASK;
		end
		else if (fe_cmd.opcode == fpep_pkg::OP_BLOCK32_CLEAR)
		begin
			lo = cmd_addr & ~fpep_pkg::BLOCK32_MASK; // R9
			hi = cmd_addr | fpep_pkg::BLOCK32_MASK;
		end
		else if (fe_cmd.opcode == fpep_pkg::OP_BLOCK64_CLEAR)
		begin
			lo = cmd_addr & ~fpep_pkg::BLOCK64_MASK; // R9
			hi = cmd_addr | fpep_pkg::BLOCK64_MASK;
		end
		else if (fe_cmd.opcode == fpep_pkg::OP_CHIP_CLEAR_A ||
			fe_cmd.opcode == fpep_pkg::OP_CHIP_CLEAR_B)
		begin
			lo = fpep_pkg::ADDR_MIN; // R9
			hi = fpep_pkg::ADDR_MAX;
		end
		else
		begin
			is_erase = 1'b0;
		end
	end

	assign write_type = fe_cmd.opcode == fpep_pkg::OP_WRITE_ENABLE ||
		fe_cmd.opcode == fpep_pkg::OP_WRITE_DISABLE ||
		fe_cmd.opcode == fpep_pkg::OP_STATUS_WRITE || is_page || is_erase;

	// ============================================================
	// Next-state logic.
	always_comb
	begin
		state_next = state_reg;
		prot_next  = prot_reg;
		wel_next   = wel_reg;
		sleep_next = sleep_reg;
		cnt_next   = cnt_reg;
		sr0_next   = sr0_reg;
		sr1_next   = sr1_reg;
		left_next  = left_reg;
		off_next   = off_reg;
		idx_next   = idx_reg;
		page_next  = page_reg;
		cur_next   = cur_reg;
		end_next   = end_reg;
		timer_next = timer_reg;
		arr_next   = '0;
		if (buf_wr)
		begin
			if (cnt_reg == 9'h0)
				sr0_next = fe_byte;
			if (cnt_reg == 9'h1)
				sr1_next = fe_byte;
			if (cnt_reg != fpep_pkg::PAGE_BYTES)
				cnt_next = cnt_reg + 9'h1;
		end
		if (fe_cmd_valid)
			cnt_next = '0;
		case (state_reg)
			fpep_pkg::ST_IDLE:
			begin
				if (fe_cmd_valid && sleep_reg)
				begin
					if (fe_cmd.opcode == fpep_pkg::OP_WAKE_AND_ID) // R15 R18
						sleep_next = 1'b0;
				end
				else if (fe_cmd_valid && (!write_type || fe_cmd.whole_bytes)) // R19
				begin
					if (fe_cmd.opcode == fpep_pkg::OP_ENTER_SLEEP)
						sleep_next = 1'b1; // R14
					else if (fe_cmd.opcode == fpep_pkg::OP_WRITE_ENABLE)
						wel_next = 1'b1;
					else if (fe_cmd.opcode == fpep_pkg::OP_WRITE_DISABLE)
						wel_next = 1'b0;
					else if (fe_cmd.opcode == fpep_pkg::OP_STATUS_WRITE && wel_reg &&
						cnt_reg != 9'h0)
					begin
						prot_next.protect_level_bits = sr0_reg[fpep_pkg::SR0_LEVEL_LSB +: 3];
						prot_next.top_bottom_choice = sr0_reg[fpep_pkg::SR0_TB_BIT];
						prot_next.fine_granularity_flag = sr0_reg[fpep_pkg::SR0_SEC_BIT];
						if (cnt_reg != 9'h1)
							prot_next.complement_protect = sr1_reg[fpep_pkg::SR1_CMP_BIT];
						timer_next = '0;
						state_next = fpep_pkg::ST_SR_WAIT;
					end
					else if (wel_reg && !hits_protect(prot_reg, lo, hi)) // R4 R21
					begin
						if (is_page && cnt_reg != 9'h0)
						begin
							page_next  = lo;
							off_next   = cmd_addr[7:0];
							idx_next   = '0;
							left_next  = cnt_reg;
							state_next = fpep_pkg::ST_PG_READ;
						end
						else if (is_erase)
						begin
							cur_next   = lo;
							end_next   = hi;
							state_next = fpep_pkg::ST_ERASE;
						end
					end
				end
			end
			fpep_pkg::ST_SR_WAIT:
			begin
				timer_next = timer_reg + 1'b1;
				if (timer_reg == fpep_pkg::TIMER_W'(fpep_pkg::SR_WRITE_CYCLES - 1))
				begin
					wel_next   = 1'b0; // R17
					state_next = fpep_pkg::ST_IDLE;
				end
			end
			fpep_pkg::ST_PG_READ:
			begin
				arr_next.rd   = 1'b1;
				arr_next.addr = {4'h0, page_reg | {12'h0, off_reg}};
				state_next    = fpep_pkg::ST_PG_WAIT;
			end
			fpep_pkg::ST_PG_WAIT:
			begin
				state_next = fpep_pkg::ST_PG_MERGE;
			end
			fpep_pkg::ST_PG_MERGE:
			begin
				arr_next.wr    = 1'b1;
				arr_next.addr  = {4'h0, page_reg | {12'h0, off_reg}};
				arr_next.wdata = arr_rdata & buf_rdata; // R7
				off_next       = off_reg + 8'h1; // R6
				idx_next       = idx_reg + 8'h1;
				left_next      = left_reg - 9'h1;
				if (left_reg == 9'h1)
				begin
					wel_next   = 1'b0; // R17
					state_next = fpep_pkg::ST_IDLE;
				end
				else
				begin
					state_next = fpep_pkg::ST_PG_READ;
				end
			end
			fpep_pkg::ST_ERASE:
			begin
				arr_next.wr    = 1'b1;
				arr_next.addr  = {4'h0, cur_reg};
				arr_next.wdata = fpep_pkg::ERASED_BYTE; // R8
				cur_next       = cur_reg + 20'h1;
				if (cur_reg == end_reg)
				begin
					wel_next   = 1'b0; // R17
					state_next = fpep_pkg::ST_IDLE;
				end
			end
			default:
			begin
				state_next = fpep_pkg::ST_IDLE;
			end
		endcase
		if (sleep_next)
			power_next = fpep_pkg::PWR_SLEEP;
		else if (!cs_sync_reg || state_next != fpep_pkg::ST_IDLE) // R12 R13
			power_next = fpep_pkg::PWR_ACTIVE;
		else
			power_next = fpep_pkg::PWR_STANDBY;
	end

	// ============================================================
	// State registers.
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			state_reg <= fpep_pkg::ST_IDLE;
			prot_reg  <= fpep_pkg::PROT_RESET;
			arr_reg   <= '0;
			power_reg <= fpep_pkg::PWR_STANDBY;
			wel_reg   <= 1'b0;
			sleep_reg <= 1'b0;
			cnt_reg   <= '0;
			sr0_reg   <= '0;
			sr1_reg   <= '0;
			left_reg  <= '0;
			off_reg   <= '0;
			idx_reg   <= '0;
			page_reg  <= '0;
			cur_reg   <= '0;
			end_reg   <= '0;
			timer_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			prot_reg  <= prot_next;
			arr_reg   <= arr_next;
			power_reg <= power_next;
			wel_reg   <= wel_next;
			sleep_reg <= sleep_next;
			cnt_reg   <= cnt_next;
			sr0_reg   <= sr0_next;
			sr1_reg   <= sr1_next;
			left_reg  <= left_next;
			off_reg   <= off_next;
			idx_reg   <= idx_next;
			page_reg  <= page_next;
			cur_reg   <= cur_next;
			end_reg   <= end_next;
			timer_reg <= timer_next;
		end
	end

	assign arr_req                = arr_reg;
	assign write_in_progress_flag = state_reg != fpep_pkg::ST_IDLE; // R11
	assign write_enable_latch     = wel_reg;
	assign prot_bits              = prot_reg;
	assign power_state            = power_reg;

endmodule

// ### tb/fpep_core_asserts.sv
`timescale 1ns/1ns
// ============================================================
// Port checks for the program, erase and power logic.
module fpep_core_asserts
(
	// Clock and reset.
	input wire logic                    ref_clk,
	input wire logic                    reset_n,
	// Inputs.
	input wire logic                    chip_sel_n_pin,
	input wire logic                    fe_cmd_valid,
	input wire fpep_pkg::fpep_cmd_t     fe_cmd,
	// Outputs.
	input wire fpep_pkg::fpep_arr_req_t arr_req,
	input wire logic                    write_in_progress_flag,
	input wire logic                    write_enable_latch,
	input wire fpep_pkg::fpep_prot_t    prot_bits,
	input wire fpep_pkg::fpep_power_t   power_state
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire logic slp  = power_state == fpep_pkg::PWR_SLEEP;
	wire logic wake = fe_cmd_valid && fe_cmd.opcode == 8'hab;
	wire logic busy = write_in_progress_flag;
	a_sleep_enter: assert property (fe_cmd_valid && fe_cmd.opcode == 8'hb9 && !busy |=> slp)
		else $error("sleep not entered");
	a_sleep_stay: assert property (slp && !wake |=> slp)
		else $error("sleep left without wake");
	a_wake_code: assert property (slp && wake |=> !slp)
		else $error("wake code did not wake");
	a_sleep_quiet: assert property (slp |-> !busy && !arr_req.wr)
		else $error("activity while asleep");
	a_busy_active: assert property (busy && $past(busy) |-> power_state == fpep_pkg::PWR_ACTIVE)
		else $error("not active while busy");
	a_select_active: assert property ((!chip_sel_n_pin)[*4] |-> power_state != fpep_pkg::PWR_STANDBY)
		else $error("standby while selected");
	a_done_clear: assert property ($fell(busy) |-> !write_enable_latch)
		else $error("latch kept after cycle");
	a_busy_deaf: assert property (busy && fe_cmd_valid |=> $stable(prot_bits) [*2] ##0 !slp)
		else $error("command taken while busy");
	a_frag_ignore: assert property (fe_cmd_valid && !fe_cmd.whole_bytes && !slp && !busy
		|=> $stable(write_enable_latch) && !busy)
		else $error("partial frame took effect");
	a_no_latch: assert property (fe_cmd_valid && !write_enable_latch && !busy |=> !busy)
		else $error("cycle started without latch");
	cover property ($fell(busy));
	cover property (slp);
	cover property (arr_req.wr && arr_req.wdata == 8'hff);
	cover property (prot_bits.complement_protect);
endmodule
bind fpep_core fpep_core_asserts chk_u (.ref_clk(ref_clk), .reset_n(reset_n),
	.chip_sel_n_pin(chip_sel_n_pin), .fe_cmd_valid(fe_cmd_valid), .fe_cmd(fe_cmd),
	.arr_req(arr_req), .write_in_progress_flag(write_in_progress_flag),
	.write_enable_latch(write_enable_latch), .prot_bits(prot_bits), .power_state(power_state));

// ### tb/fpep_array_model.sv
`timescale 1ns/1ns
// ============================================================
// Array model: 1 MB of bytes, erased at start.
module fpep_array_model
(
	// Clock.
	input wire logic                    ref_clk,
	// Array port.
	input wire fpep_pkg::fpep_arr_req_t arr_req,
	output logic [7:0]                  arr_rdata
);
	logic [7:0] mem [0:1048575];
	logic [7:0] rd_reg;
	logic [1:0] hold_reg;
	initial
	begin
		for (int i = 0; i < 1048576; i++)
			mem[i] = 8'hff;
		rd_reg = 8'h00;
		hold_reg = 2'h0;
	end
	always @(posedge ref_clk)
	begin
		if (arr_req.wr)
			mem[arr_req.addr[19:0]] <= arr_req.wdata;
		if (arr_req.rd)
		begin
			rd_reg <= mem[arr_req.addr[19:0]];
			hold_reg <= 2'h2;
		end
		else if (hold_reg != 2'h0)
			hold_reg <= hold_reg - 2'h1;
	end
	// Read data is valid for two cycles only, inverted outside them.
	assign arr_rdata = (hold_reg != 2'h0) ? rd_reg : ~rd_reg;
endmodule

// ### tb/tb.sv
`timescale 1ns/1ns
// ============================================================
// Self-checking bench for the program, erase and protection core.
module tb;
	typedef struct packed {logic [7:0] s0; logic [19:0] a; logic ok;} fpep_row_t;
	logic                    ref_clk = 0, reset_n = 0, chip_sel_n_pin = 1;
	logic                    fe_byte_valid = 0, fe_cmd_valid = 0;
	logic [7:0]              fe_byte = 8'h00, arr_rdata, old, d;
	fpep_pkg::fpep_cmd_t     fe_cmd = '0;
	fpep_pkg::fpep_arr_req_t arr_req;
	fpep_pkg::fpep_prot_t    prot_bits;
	fpep_pkg::fpep_power_t   power_state;
	logic                    write_in_progress_flag, write_enable_latch;
	int                      failures = 0, cmp_count = 0, cyc = 0;
	fpep_row_t rows [11] = '{'{8'h00, 20'hfffff, 1'b0}, '{8'h14, 20'h00000, 1'b1},
		'{8'h18, 20'h80000, 1'b1}, '{8'h04, 20'hf0000, 1'b1}, '{8'h04, 20'heffff, 1'b0},
		'{8'h24, 20'h0ffff, 1'b1}, '{8'h24, 20'h10000, 1'b0}, '{8'h44, 20'hff000, 1'b1},
		'{8'h44, 20'hfefff, 1'b0}, '{8'h70, 20'h07fff, 1'b1}, '{8'h74, 20'h07fff, 1'b1}};
	logic [7:0]              clr_ops [4] = '{8'h52, 8'hd8, 8'hc7, 8'h60};
	always #4 ref_clk = ~ref_clk;
	fpep_core dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .chip_sel_n_pin(chip_sel_n_pin),
		.fe_byte_valid(fe_byte_valid), .fe_byte(fe_byte), .fe_cmd_valid(fe_cmd_valid),
		.fe_cmd(fe_cmd), .arr_req(arr_req), .arr_rdata(arr_rdata),
		.write_in_progress_flag(write_in_progress_flag),
		.write_enable_latch(write_enable_latch), .prot_bits(prot_bits),
		.power_state(power_state));
	fpep_array_model arr_u (.ref_clk(ref_clk), .arr_req(arr_req), .arr_rdata(arr_rdata));
	task automatic results;
		$display("failures %0d, comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic byt(input logic [7:0] b);
		@(negedge ref_clk);
		fe_byte_valid = 1;
		fe_byte = b;
		@(negedge ref_clk);
		fe_byte_valid = 0;
	endtask
	task automatic cmd(input logic [7:0] op, input logic [19:0] a, input logic w);
		@(negedge ref_clk);
		fe_cmd_valid = 1;
		fe_cmd = '{op, {4'h0, a}, w};
		@(negedge ref_clk);
		fe_cmd_valid = 0;
		@(negedge ref_clk);
	endtask
	task automatic idle;
		for (int n = 0; n < 6000 && write_in_progress_flag !== 1'b0; n++)
			@(negedge ref_clk);
		if (write_in_progress_flag !== 1'b0)
		begin
			failures++;
			$display("wrong value at %0t: busy flag never cleared", $time);
		end
		@(negedge ref_clk);
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			failures++;
			results();
		end
	end
	initial
	begin
		repeat (3) @(negedge ref_clk);
		reset_n = 1;
		@(negedge ref_clk);
		chk({write_in_progress_flag, write_enable_latch, prot_bits}, 8'h00);
		chk(8'(power_state), 8'(fpep_pkg::PWR_STANDBY));
		foreach (rows[i])
		begin
			cmd(8'h06, 20'h0, 1);
			byt(rows[i].s0);
			byt(8'h40);
			cmd(8'h01, 20'h0, 1);
			idle();
			d = {i[3:0], ~i[3:0]};
			old = arr_u.mem[rows[i].a];
			cmd(8'h06, 20'h0, 1);
			byt(d);
			cmd(8'h02, rows[i].a, 1);
			chk(8'(write_in_progress_flag), 8'(rows[i].ok));
			idle();
			chk(8'(write_enable_latch), 8'(!rows[i].ok));
			chk(arr_u.mem[rows[i].a], rows[i].ok ? (old & d) : old);
		end
		cmd(8'h06, 20'h0, 1);
		cmd(8'h20, 20'h07123, 1);
		idle();
		chk(arr_u.mem[20'h07000] & arr_u.mem[20'h07fff], 8'hff);
		foreach (clr_ops[k])
		begin
			cmd(8'h06, 20'h0, 1);
			cmd(clr_ops[k], 20'h10000, 1);
			chk(8'(write_in_progress_flag), 8'h00);
		end
		cmd(8'h04, 20'h0, 0);
		chk(8'(write_enable_latch), 8'h01);
		cmd(8'h04, 20'h0, 1);
		cmd(8'h20, 20'h07000, 1);
		chk(8'(write_in_progress_flag), 8'h00);
		cmd(8'h06, 20'h0, 1);
		byt(8'h70);
		cmd(8'h01, 20'h0, 1);
		chk(8'(power_state), 8'(fpep_pkg::PWR_ACTIVE));
		cmd(8'hb9, 20'h0, 1);
		idle();
		@(negedge ref_clk);
		chk(8'(power_state), 8'(fpep_pkg::PWR_STANDBY));
		cmd(8'hb9, 20'h0, 1);
		chk(8'(power_state), 8'(fpep_pkg::PWR_SLEEP));
		cmd(8'h06, 20'h0, 1);
		chk(8'(write_enable_latch), 8'h00);
		cmd(8'hab, 20'h0, 0);
		chk(8'(power_state), 8'(fpep_pkg::PWR_STANDBY));
		chip_sel_n_pin = 0;
		repeat (4) @(negedge ref_clk);
		chk(8'(power_state), 8'(fpep_pkg::PWR_ACTIVE));
		chip_sel_n_pin = 1;
		repeat (4) @(negedge ref_clk);
		chk(8'(power_state), 8'(fpep_pkg::PWR_STANDBY));
		cmd(8'h06, 20'h0, 1);
		reset_n = 0;
		repeat (2) @(negedge ref_clk);
		reset_n = 1;
		@(negedge ref_clk);
		chk({write_in_progress_flag, write_enable_latch, prot_bits}, 8'h00);
		chk(8'(power_state), 8'(fpep_pkg::PWR_STANDBY));
		results();
	end
endmodule
